// ==== src/sc_stats_defs.vh ====
`ifndef SC_STATS_DEFS_VH
`define SC_STATS_DEFS_VH

// ==========================================================
// Counter geometry
`define SC_CNT_W 32
`define SC_NUM_CNT 19
`define SC_NUM_BASIC 16
`define SC_IDX_W 5
`define SC_PEND_W 2
`define SC_ID_STEP 4
`define SC_CNT_RST 32'h00000000

// ==========================================================
// Counter index (byte offset in snapshot is four times index)
`define SC_IDX_BASE_N 10
`define SC_IDX_RX_CRC 5'h0a
`define SC_IDX_RX_ALIGN 5'h0b
`define SC_IDX_RX_RSRC 5'h0c
`define SC_IDX_RX_OVRN 5'h0d
`define SC_IDX_RX_COLL 5'h0e
`define SC_IDX_RX_SHORT 5'h0f
`define SC_IDX_TX_PAUSE 5'h10
`define SC_IDX_RX_PAUSE 5'h11
`define SC_IDX_RX_UNSUP 5'h12

`endif

// ==== src/sc_pend.v ====
`timescale 1ns/1ps

// ==========================================================
// Pending increment tally for one counter
module sc_pend #(
    parameter PW = 2
) (
    input wire mclk,
    input wire reset,
    input wire inc,
    input wire take,
    output reg [PW-1:0] pend_r
);

reg [PW-1:0] pend_nxt;

// Arrival and service in the same cycle cancel; saturates at the top
always @*
begin
    pend_nxt = pend_r;
    if (take && !inc)
    begin
        pend_nxt = pend_r - {{(PW-1){1'b0}}, 1'b1};
    end
    else if (inc && !take && (pend_r != {PW{1'b1}}))
    begin
        pend_nxt = pend_r + {{(PW-1){1'b0}}, 1'b1};
    end
end

always @(posedge mclk or posedge reset)
begin
    if (reset)
    begin
        pend_r <= {PW{1'b0}};
    end
    else
    begin
        pend_r <= pend_nxt;
    end
end

endmodule // sc_pend

// ==== src/sc_stats.v ====
`timescale 1ns/1ps
`include "sc_stats_defs.vh"

// Function
// RULE_01: Alignment counter counts misaligned frames with CRC error, any receive state.
// RULE_02: CRC, alignment, short exclusive; short frame bumps only short counter.
// RULE_03: Resource counter counts good frames dropped for lack of resources.
// RULE_04: Save-bad-frames with bad status suppresses resource counter increment.
// RULE_05: Overrun counter counts only frames flagged lost by bus unavailability.
// RULE_06: Receive collision counter counts frames with collision during reception.
// RULE_07: Short frame counter counts frames below minimum legal length.
// RULE_08: Transmit pause counter counts every sent Xoff and Xon frame.
// RULE_09: Receive pause counter counts every received Xoff and Xon frame.
// RULE_10: Unsupported counter counts valid control frames with non-pause opcode.
// RULE_11: All counters zero after reset; only zero may ever be loaded.
// RULE_12: Updates are internal read, increment, write-back with no host traffic.
// RULE_13: Counters wrap to zero past maximum, no saturation.
// RULE_14: One frame updates every counter whose condition it meets.
// RULE_15: Every counter is 32 bits wide.
// RULE_16: Dump command writes a snapshot of counters into main memory.
// RULE_17: Nineteen counters held; dump holds 16 or 19 per extended bits.
// RULE_18: Counters update only at end of transmission or reception of frame; base_inc counters 0 to 9 are not gated by tx_done or rx_done.
// RULE_19: Dump-and-reset writes snapshot then clears counters.
// RULE_20: Counter word sits at byte offset four times index, ascending order.
module sc_stats #(
    parameter CW = `SC_CNT_W,
    parameter NC = `SC_NUM_CNT,
    parameter NB = `SC_NUM_BASIC,
    parameter PW = `SC_PEND_W
) (
    input wire mclk,
    input wire reset,
    input wire tx_done,
    input wire tx_pause,
    input wire [`SC_IDX_BASE_N-1:0] base_inc,
    input wire rx_done,
    input wire rx_crc_err,
    input wire rx_misaligned,
    input wire rx_short,
    input wire rx_good,
    input wire rx_no_rsrc,
    input wire save_bad_frames,
    input wire rx_bad_status,
    input wire rx_overrun,
    input wire rx_collision,
    input wire rx_pause,
    input wire rx_ctl_unsup,
    input wire dump_req,
    input wire dump_clear,
    input wire ext_stats,
    input wire [31:0] dump_base,
    input wire mem_wr_ready,
    output reg mem_wr_valid_r,
    output reg [31:0] mem_wr_addr_r,
    output reg [CW-1:0] mem_wr_data_r,
    output reg dump_done_r,
    output reg busy_r
);

// ==========================================================
// States
localparam S_IDLE = 3'h0;
localparam S_RD = 3'h1;
localparam S_WR = 3'h2;
localparam S_DRD = 3'h3;
localparam S_DWR = 3'h4;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [`SC_IDX_W-1:0] idx_r;
reg [`SC_IDX_W-1:0] idx_nxt;
reg [CW-1:0] rd_r;
reg dump_pend_r;
reg dump_clr_r;
reg dump_ext_r;
reg [CW-1:0] cnt_mem [0:NC-1];
reg [NC-1:0] inc;
reg [NC-1:0] take;
wire [NC-1:0] has_pend;
wire [`SC_IDX_W-1:0] sel;
wire [`SC_IDX_W-1:0] last_idx;
integer i;

// ==========================================================
// Helpers
// Lowest index with an update waiting
function [`SC_IDX_W-1:0] first_set;
    input [NC-1:0] v;
    integer k;
    begin
        first_set = {`SC_IDX_W{1'b0}};
        for (k = NC - 1; k >= 0; k = k - 1)
        begin
            if (v[k])
            begin
                first_set = k[`SC_IDX_W-1:0];
            end
        end
    end
endfunction

// Snapshot byte offset of a counter
function [31:0] id_offset;
    input [`SC_IDX_W-1:0] ix;
    begin
        id_offset = {27'h0000000, ix} * `SC_ID_STEP;
    end
endfunction

// ==========================================================
// Frame event decode
// Receive and pause events are sampled only on frame completion strobes; base_inc is not gated [RULE_18]
always @*
begin
    inc = {NC{1'b0}};
    inc[`SC_IDX_BASE_N-1:0] = base_inc;
    // Short takes precedence over CRC and alignment [RULE_02] [RULE_07]
    inc[`SC_IDX_RX_SHORT] = rx_done && rx_short;
    inc[`SC_IDX_RX_CRC] = rx_done && !rx_short && !rx_misaligned && rx_crc_err; // [RULE_02]
    // Independent of receive unit state [RULE_01]
    inc[`SC_IDX_RX_ALIGN] = rx_done && !rx_short && rx_misaligned && rx_crc_err;
    // Good frame dropped, not a saved bad frame [RULE_03] [RULE_04]
    inc[`SC_IDX_RX_RSRC] = rx_done && rx_good && rx_no_rsrc &&
                           !(save_bad_frames && rx_bad_status);
    inc[`SC_IDX_RX_OVRN] = rx_done && rx_overrun; // [RULE_05]
    inc[`SC_IDX_RX_COLL] = rx_done && rx_collision; // [RULE_06]
    inc[`SC_IDX_TX_PAUSE] = tx_done && tx_pause; // [RULE_08]
    inc[`SC_IDX_RX_PAUSE] = rx_done && rx_pause; // [RULE_09]
    inc[`SC_IDX_RX_UNSUP] = rx_done && rx_ctl_unsup; // [RULE_10]
end

// ==========================================================
// Pending update tallies, one per counter
// Several counters may be flagged by one frame [RULE_14]
genvar g;
generate
    for (g = 0; g < NC; g = g + 1)
    begin : g_pend
        wire [PW-1:0] pcnt;
        sc_pend #(
            .PW(PW)
        ) u_pend (
            .mclk(mclk),
            .reset(reset),
            .inc(inc[g]),
            .take(take[g]),
            .pend_r(pcnt)
        );
        assign has_pend[g] = |pcnt;
    end
endgenerate

assign sel = first_set(has_pend);
assign last_idx = dump_ext_r ? NC[`SC_IDX_W-1:0] - 5'h01 : NB[`SC_IDX_W-1:0] - 5'h01; // [RULE_17]

// Service one pending update when idle and no dump is waiting
always @*
begin
    take = {NC{1'b0}};
    if ((state_r == S_IDLE) && !dump_pend_r && (|has_pend))
    begin
        take[sel] = 1'b1;
    end
end

// ==========================================================
// Sequencer next state
always @*
begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
        S_IDLE:
        begin
            if (dump_pend_r)
            begin
                idx_nxt = {`SC_IDX_W{1'b0}};
                state_nxt = S_DRD;
            end
            else if (|has_pend)
            begin
                idx_nxt = sel;
                state_nxt = S_RD;
            end
        end
        S_RD:
        begin
            state_nxt = S_WR;
        end
        S_WR:
        begin
            state_nxt = S_IDLE;
        end
        S_DRD:
        begin
            state_nxt = S_DWR;
        end
        S_DWR:
        begin
            if (mem_wr_ready)
            begin
                if (idx_r == last_idx)
                begin
                    state_nxt = S_IDLE;
                end
                else
                begin
                    idx_nxt = idx_r + 5'h01; // Ascending order [RULE_20]
                    state_nxt = S_DRD;
                end
            end
        end
        default:
        begin
            state_nxt = S_IDLE;
        end
    endcase
end

// ==========================================================
// Sequencer registers and dump request latch
always @(posedge mclk or posedge reset)
begin
    if (reset)
    begin
        state_r <= S_IDLE;
        idx_r <= {`SC_IDX_W{1'b0}};
        dump_pend_r <= 1'b0;
        dump_clr_r <= 1'b0;
        dump_ext_r <= 1'b0;
        busy_r <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        idx_r <= idx_nxt;
        // Waiting updates count as busy; a dump latched in idle still goes before them
        busy_r <= (state_nxt != S_IDLE) || dump_pend_r || dump_req || (|has_pend) || (|inc);
        // New request wins over the clear at dump start [RULE_16]
        if (dump_req && (state_r != S_DRD) && (state_r != S_DWR))
        begin
            dump_pend_r <= 1'b1;
            dump_clr_r <= dump_clear; // [RULE_19]
            dump_ext_r <= ext_stats; // [RULE_17]
        end
        else if ((state_r == S_IDLE) && dump_pend_r)
        begin
            dump_pend_r <= 1'b0;
        end
    end
end

// ==========================================================
// Counter storage: read, increment, write-back
// Internal only, no bus traffic for updates [RULE_12]
always @(posedge mclk or posedge reset)
begin
    if (reset)
    begin
        rd_r <= `SC_CNT_RST;
        for (i = 0; i < NC; i = i + 1)
        begin
            cnt_mem[i] <= `SC_CNT_RST; // [RULE_11] [RULE_15]
        end
    end
    else
    begin
        case (state_r)
            S_RD:
            begin
                rd_r <= cnt_mem[idx_r]; // [RULE_12]
            end
            S_WR:
            begin
                // Natural 32-bit overflow wraps to zero [RULE_13]
                cnt_mem[idx_r] <= rd_r + {{(CW-1){1'b0}}, 1'b1}; // [RULE_12]
            end
            S_DRD:
            begin
                if (dump_clr_r)
                begin
                    cnt_mem[idx_r] <= `SC_CNT_RST; // Only zero is loadable [RULE_11] [RULE_19]
                end
            end
            S_DWR:
            begin
                // Short dump still clears the extended counters
                if (mem_wr_ready && (idx_r == last_idx) && dump_clr_r && !dump_ext_r)
                begin
                    for (i = NB; i < NC; i = i + 1)
                    begin
                        cnt_mem[i] <= `SC_CNT_RST; // [RULE_19]
                    end
                end
            end
            default:
            begin
                rd_r <= rd_r;
            end
        endcase
    end
end

// ==========================================================
// Snapshot write port to main memory
always @(posedge mclk or posedge reset)
begin
    if (reset)
    begin
        mem_wr_valid_r <= 1'b0;
        mem_wr_addr_r <= 32'h00000000;
        mem_wr_data_r <= `SC_CNT_RST;
        dump_done_r <= 1'b0;
    end
    else
    begin
        dump_done_r <= 1'b0;
        if (state_r == S_DRD)
        begin
            mem_wr_valid_r <= 1'b1; // [RULE_16]
            mem_wr_addr_r <= dump_base + id_offset(idx_r); // [RULE_20]
            mem_wr_data_r <= cnt_mem[idx_r];
        end
        else if ((state_r == S_DWR) && mem_wr_ready)
        begin
            mem_wr_valid_r <= 1'b0;
            if (idx_r == last_idx)
            begin
                dump_done_r <= 1'b1; // Snapshot complete [RULE_17]
            end
        end
    end
end

endmodule // sc_stats

// ==== tb/sc_stats_properties.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checker for the snapshot dump
module sc_stats_chk (
    input wire mclk,
    input wire reset,
    input wire dump_req,
    input wire [31:0] dump_base,
    input wire mem_wr_ready,
    input wire mem_wr_valid_r,
    input wire [31:0] mem_wr_addr_r,
    input wire [31:0] mem_wr_data_r,
    input wire dump_done_r,
    input wire busy_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    reset_idle_a: assert property ($fell(reset) |->
        !mem_wr_valid_r && !dump_done_r && !busy_r) else $error("outputs not idle");
    word_hold_a: assert property (mem_wr_valid_r && !mem_wr_ready |=> mem_wr_valid_r
        && $stable(mem_wr_addr_r) && $stable(mem_wr_data_r)) else $error("word not held");
    word_gap_a: assert property (mem_wr_valid_r && mem_wr_ready |=>
        !mem_wr_valid_r) else $error("no idle after accept");
    addr_step_a: assert property ((mem_wr_valid_r && mem_wr_ready) ##1
        !dump_done_r ##1 mem_wr_valid_r |-> mem_wr_addr_r == $past(mem_wr_addr_r, 2) + 32'h4)
        else $error("address not ascending");
    addr_range_a: assert property (mem_wr_valid_r |-> mem_wr_addr_r[1:0] ==
        dump_base[1:0] && (mem_wr_addr_r - dump_base) <= 32'h48) else $error("address range");
    dump_start_a: assert property (dump_req && !busy_r |-> ##[1:8]
        mem_wr_valid_r && mem_wr_addr_r == dump_base) else $error("dump did not start");
    dump_end_a: assert property (dump_done_r |-> $past(mem_wr_valid_r) &&
        $past(mem_wr_ready) && ($past(mem_wr_addr_r) - dump_base == 32'h3c ||
        $past(mem_wr_addr_r) - dump_base == 32'h48)) else $error("done not after last");
    done_pulse_a: assert property (dump_done_r |=> !dump_done_r)
        else $error("done longer than one cycle");
endmodule // sc_stats_chk

bind sc_stats sc_stats_chk u_chk (
    .mclk(mclk), .reset(reset), .dump_req(dump_req), .dump_base(dump_base),
    .mem_wr_ready(mem_wr_ready), .mem_wr_valid_r(mem_wr_valid_r),
    .mem_wr_addr_r(mem_wr_addr_r), .mem_wr_data_r(mem_wr_data_r),
    .dump_done_r(dump_done_r), .busy_r(busy_r));

// ==== tb/sc_mem_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Snapshot memory behind the dump port
module sc_mem_model (
    input wire mclk,
    input wire reset,
    input wire slow,
    input wire mem_wr_valid_r,
    input wire [31:0] mem_wr_addr_r,
    input wire [31:0] mem_wr_data_r,
    output reg mem_wr_ready
);
    reg [31:0] mem [0:31];
    integer nwr;
    // Word store by byte offset, ready slow or prompt
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            mem_wr_ready <= 1'b0;
            nwr = 0;
        end
        else
        begin
            if (mem_wr_valid_r && mem_wr_ready)
            begin
                mem[mem_wr_addr_r[6:2]] <= mem_wr_data_r;
                nwr = nwr + 1;
            end
            mem_wr_ready <= slow ? ~mem_wr_ready : 1'b1;
        end
    end
endmodule // sc_mem_model

// ==== tb/tb_sc_stats.sv ====
`timescale 1ns/1ps
// ==========================================
// Bench for the statistics counter unit
module tb_sc_stats;
    reg mclk, reset, dump_req, dump_clear, ext_stats, slow;
    reg [23:0] ev;
    reg [42:0] rows [0:11];
    reg [31:0] ex [0:18];
    wire rdy, vld, done, busy;
    wire [31:0] addr, data;
    integer errors, compares, r, i;
    sc_stats u_dut (
        .mclk(mclk), .reset(reset), .tx_done(ev[13]), .tx_pause(ev[12]),
        .base_inc(ev[23:14]), .rx_done(ev[11]), .rx_crc_err(ev[10]), .rx_misaligned(ev[9]),
        .rx_short(ev[8]), .rx_good(ev[7]), .rx_no_rsrc(ev[6]), .save_bad_frames(ev[5]),
        .rx_bad_status(ev[4]), .rx_overrun(ev[3]), .rx_collision(ev[2]), .rx_pause(ev[1]),
        .rx_ctl_unsup(ev[0]), .dump_req(dump_req), .dump_clear(dump_clear),
        .ext_stats(ext_stats), .dump_base(32'h00004000), .mem_wr_ready(rdy),
        .mem_wr_valid_r(vld), .mem_wr_addr_r(addr), .mem_wr_data_r(data),
        .dump_done_r(done), .busy_r(busy));
    sc_mem_model u_mem (
        .mclk(mclk), .reset(reset), .slow(slow), .mem_wr_valid_r(vld),
        .mem_wr_addr_r(addr), .mem_wr_data_r(data), .mem_wr_ready(rdy));
    // ==========================================
    // Shared tasks
    task chk(input [31:0] g, input [31:0] e);
        begin
            compares = compares + 1;
            if (g !== e)
            begin
                errors = errors + 1;
                $display("Error t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task complete_run;
        begin
            if (errors == 0 && compares > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task dump(input reg ext, input reg clr, input integer n);
        integer k, w0;
        begin
            k = 0;
            while (busy && k < 100)
            begin
                @(negedge mclk);
                k = k + 1;
            end
            w0 = u_mem.nwr;
            dump_req = 1'b1;
            ext_stats = ext;
            dump_clear = clr;
            @(negedge mclk);
            dump_req = 1'b0;
            while (!done && k < 500)
            begin
                @(negedge mclk);
                k = k + 1;
            end
            chk({31'h0, done}, 32'h1);
            chk(u_mem.nwr - w0, n);
            for (k = 0; k < n; k = k + 1)
                chk(u_mem.mem[k], ex[k]);
            if (clr)
                for (k = 0; k < 19; k = k + 1)
                    ex[k] = 32'h0;
            @(negedge mclk);
        end
    endtask
    // ==========================================
    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Watchdog
    initial
    begin
        #200000;
        errors = errors + 1;
        complete_run;
    end
    // ==========================================
    // Main sequence
    initial
    begin
        {reset, dump_req, dump_clear, ext_stats, slow} = 5'h10;
        ev = 24'h0;
        errors = 0;
        compares = 0;
        for (i = 0; i < 19; i = i + 1)
            ex[i] = 32'h0;
        rows[0] = {24'h000f04, 19'h0c000};
        rows[1] = {24'h000e00, 19'h00800};
        rows[2] = {24'h000c00, 19'h00400};
        rows[3] = {24'h0008c0, 19'h01000};
        rows[4] = {24'h0008f0, 19'h00000};
        rows[5] = {24'h0008e0, 19'h01000};
        rows[6] = {24'h000c0f, 19'h66400};
        rows[7] = {24'h003000, 19'h10000};
        rows[8] = {24'h002000, 19'h00000};
        rows[9] = {24'hffc000, 19'h003ff};
        rows[10] = {24'h00040f, 19'h00000};
        rows[11] = {24'h000802, 19'h20000};
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        for (r = 0; r < 12; r = r + 1)
        begin
            ev = rows[r][42:19];
            @(negedge mclk);
            ev = 24'h0;
            for (i = 0; i < 19; i = i + 1)
                ex[i] = ex[i] + {31'h0, rows[r][i]};
            repeat (3) @(negedge mclk);
        end
        // Three collisions back to back queue up
        ev = 24'h000804;
        repeat (3) @(negedge mclk);
        ev = 24'h0;
        ex[14] = ex[14] + 32'h3;
        dump(1'b1, 1'b0, 19);
        slow = 1'b1;
        dump(1'b0, 1'b1, 16);
        dump(1'b1, 1'b0, 19);
        slow = 1'b0;
        // Counter at its top wraps to zero on the next event
        u_dut.cnt_mem[18] = 32'hffffffff;
        ev = 24'h000801;
        @(negedge mclk);
        ev = 24'h0;
        dump(1'b1, 1'b1, 19);
        // Reset in mid-run clears counters
        ev = 24'h000c0f;
        @(negedge mclk);
        ev = 24'h0;
        reset = 1'b1;
        @(negedge mclk);
        reset = 1'b0;
        dump(1'b1, 1'b0, 19);
        complete_run;
    end
endmodule // tb_sc_stats
